// [ugmpa_core.sv]
// Pixel addressing, packing and fetch for the unified graphics memory.
// Assumes one outstanding read and a memory that raises readDataStrobe with data.
`timescale 1ns/10ps
module ugmpa_core #(
  parameter int MEM_DATA_W = 32              // 16 or 32
) (
  input wire logic clk,                       // 200 MHz clock
  input wire logic reset_n,                   // Synchronous reset, active low
  input wire logic reqValid,                  // Access request offered
  input wire ugmpa_pkg::ugmpa_req_t req,      // Access request
  input wire logic [31:0] paletteColor,       // Palette entry of fetched index
  input wire logic [MEM_DATA_W-1:0] memoryDataLinesIn, // Data pins, input side
  input wire logic readDataStrobe,            // Memory read data present, pin
  output logic busy,                          // Request not taken while high
  output logic [ugmpa_pkg::ADDR_W-2:0] memAddress, // A22..A1
  output logic memReadStrobe,                 // One-cycle read command
  output logic memWriteStrobe,                // One-cycle write command
  output logic upperByteMask0,                // Lane 1 masked when high
  output logic lowerByteMask0,                // Lane 0 masked when high
  output logic upperByteMask1,                // Lane 3 masked when high
  output logic lowerByteMask1,                // Lane 2 masked when high
  output logic [MEM_DATA_W-1:0] memoryDataLinesOut, // Data pins, output side
  output logic memoryDataLinesOe,             // Drives data pins when high
  output logic displayValid,                  // One-cycle display colour ready
  output logic [ugmpa_pkg::DISP_W-1:0] internalDisplayColorWord, // Colour
  output logic pixelTransparent               // Lower layer shows through
);

  localparam int LANES = MEM_DATA_W / 8;
  localparam int LANE_W = (LANES > 2) ? 2 : 1;

  // ==========================================================================
  // Coordinate mapping
  function automatic logic [ugmpa_pkg::ADDR_W-1:0] mapAddr(input ugmpa_pkg::ugmpa_req_t r);
    logic [ugmpa_pkg::Y_LOW_W-1:0] yLow;
    yLow = r.y[ugmpa_pkg::Y_LOW_W-1:0];
    if (r.linear) begin
      return r.linearAddr;
    end
    // Low nine bits always stay inside one 512-byte unit
    unique case ({r.pix16, r.memoryWidthSelect})
      2'b00: return {r.y[13:4], r.x[8:5], yLow, r.x[ugmpa_pkg::X_LOW8_W-1:0]};
      2'b01: return {r.y[12:4], r.x[9:5], yLow, r.x[ugmpa_pkg::X_LOW8_W-1:0]};
      2'b10: return {r.y[12:4], r.x[8:4], yLow, r.x[ugmpa_pkg::X_LOW16_W-1:0], 1'b0};
      2'b11: return {r.y[11:4], r.x[9:4], yLow, r.x[ugmpa_pkg::X_LOW16_W-1:0], 1'b0};
      default: return ugmpa_pkg::ORIGIN_ADDR;
    endcase
  endfunction

  // Lane number of a byte address on this bus width
  function automatic logic [1:0] laneOf(input logic [ugmpa_pkg::ADDR_W-1:0] a);
    if (LANES > 2) begin
      return a[1:0];
    end
    return {1'b0, a[0]};
  endfunction

  // Byte masks: high masks a lane; on writes A0 and A1 decide which, reads open all lanes
  function automatic logic [3:0] maskOf(input logic [ugmpa_pkg::ADDR_W-1:0] a,
                                        input logic pix16, input logic isWrite);
    logic [3:0] en;
    logic [1:0] lane;
    lane = laneOf(a);
    en = 4'h0;
    if (!isWrite) begin
      en = 4'hf;
    end else if (pix16) begin
      en[{lane[1], 1'b0}] = 1'b1;
      en[{lane[1], 1'b1}] = 1'b1;
    end else begin
      en[lane] = 1'b1;
    end
    if (LANES <= 2) begin
      en[3:2] = en[1:0]; // 16-bit bus: upper pair mirrors lower
    end
    return ~en;
  endfunction

  // ==========================================================================
  // Pin input synchronisers
  logic [MEM_DATA_W-1:0] dataSync1;
  logic [MEM_DATA_W-1:0] dataSync2;
  logic strobeSync1;
  logic strobeSync2;
  logic strobeSeen;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dataSync1 <= '0;
      dataSync2 <= '0;
      strobeSync1 <= 1'b0;
      strobeSync2 <= 1'b0;
      strobeSeen <= 1'b0;
    end else begin
      dataSync1 <= memoryDataLinesIn;
      dataSync2 <= dataSync1;
      strobeSync1 <= readDataStrobe;
      strobeSync2 <= strobeSync1;
      strobeSeen <= strobeSync2;
    end
  end

  // ==========================================================================
  // Access sequencing
  ugmpa_pkg::ugmpa_state_t state;
  logic take;
  logic readDone;
  logic [ugmpa_pkg::ADDR_W-1:0] byteAddr;

  assign take = reqValid && state == ugmpa_pkg::ST_IDLE;
  // Rising edge only: a strobe still held from the last read must not end the next
  assign readDone = state == ugmpa_pkg::ST_WAIT_READ && strobeSync2 && !strobeSeen;
  assign byteAddr = mapAddr(req);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ugmpa_pkg::ST_IDLE;
    end else begin
      unique case (state)
        ugmpa_pkg::ST_IDLE: begin
          if (take && !req.isWrite) begin
            state <= ugmpa_pkg::ST_WAIT_READ;
          end
        end
        ugmpa_pkg::ST_WAIT_READ: begin
          if (readDone) begin
            state <= ugmpa_pkg::ST_IDLE;
          end
        end
        default: state <= ugmpa_pkg::ST_IDLE;
      endcase
    end
  end

  // Busy is held through the read so a second fetch cannot lose its lane
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (take && !req.isWrite) || (state == ugmpa_pkg::ST_WAIT_READ && !readDone);
    end
  end

  // ==========================================================================
  // Memory command, address and masks
  logic [3:0] masks;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memAddress <= ugmpa_pkg::MEM_ADDR_RESET;
      memReadStrobe <= 1'b0;
      memWriteStrobe <= 1'b0;
      masks <= 4'hf;
    end else begin
      memReadStrobe <= take && !req.isWrite;
      memWriteStrobe <= take && req.isWrite;
      if (take) begin
        memAddress <= byteAddr[ugmpa_pkg::ADDR_W-1:1];
        masks <= maskOf(byteAddr, req.pix16, req.isWrite);
      end
    end
  end

  assign lowerByteMask0 = masks[0];
  assign upperByteMask0 = masks[1];
  assign lowerByteMask1 = masks[2];
  assign upperByteMask1 = masks[3];

  // ==========================================================================
  // Write data packing
  // Pixel is copied to every lane or lane pair; the masks keep only the addressed one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memoryDataLinesOut <= '0;
      memoryDataLinesOe <= 1'b0;
    end else begin
      memoryDataLinesOe <= take && req.isWrite;
      if (take && req.isWrite) begin
        if (req.pix16) begin
          memoryDataLinesOut <= {(MEM_DATA_W / 16){req.writePixel}};
        end else begin
          memoryDataLinesOut <= {LANES{req.writePixel[7:0]}};
        end
      end
    end
  end

  // ==========================================================================
  // Read data extraction
  logic [1:0] heldLane;
  logic heldPix16;
  logic heldOdd;
  ugmpa_pkg::ugmpa_pix_mode_t heldMode;
  logic heldOverlay;
  logic [15:0] fetched;
  ugmpa_pkg::ugmpa_color_t colorOut;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      heldLane <= 2'h0;
      heldPix16 <= 1'b0;
      heldOdd <= 1'b0;
      heldMode <= ugmpa_pkg::PIX_DIRECT16;
      heldOverlay <= 1'b0;
    end else if (take && !req.isWrite) begin
      heldLane <= laneOf(byteAddr);
      heldPix16 <= req.pix16;
      heldOdd <= req.x[0];
      heldMode <= req.pixMode;
      heldOverlay <= req.overlay;
    end
  end

  // Lower lanes hold lower pixel numbers, i.e. pixels further left
  always_comb begin
    logic [31:0] wide;
    wide = 32'(dataSync2);
    fetched = 16'(wide >> {heldLane, 3'b000});
    if (!heldPix16) begin
      fetched[15:8] = 8'h00;
    end
  end

  ugmpa_color colorer (
    .clk(clk),
    .reset_n(reset_n),
    .pixelValid(readDone),
    .pixel(fetched),
    .pixelOdd(heldOdd),
    .pixMode(heldMode),
    .overlay(heldOverlay),
    .paletteColor(paletteColor),
    .result(colorOut)
  );

  // ==========================================================================
  // Display colour output
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      displayValid <= 1'b0;
      internalDisplayColorWord <= ugmpa_pkg::DISP_RESET;
      pixelTransparent <= 1'b0;
    end else begin
      displayValid <= readDone;
      if (readDone) begin
        internalDisplayColorWord <= colorOut.color;
        pixelTransparent <= colorOut.transparent;
      end
    end
  end

  // Coordinates beyond the row width wrap into the field widths

endmodule

// [ugmpa_pkg.sv]
// Shared constants and carriers for the graphics memory pixel addressing block.
// Assumes a single clock domain and an external word-wide graphics memory.
package ugmpa_pkg;

  // ==========================================================================
  // Address layout
  localparam int ADDR_W = 23;             // Byte address bits A22..A0
  localparam int X_W = 10;                // Up to 1024 pixels per row
  localparam int Y_W = 14;                // Enough rows to fill the address space
  localparam int Y_LOW_W = 4;             // Y lower field inside one memory unit
  localparam int X_LOW8_W = 5;            // X lower field, 8 bits per pixel
  localparam int X_LOW16_W = 4;           // X lower field, 16 bits per pixel
  localparam int UNIT_BYTES = 512;        // One memory unit
  localparam logic [ADDR_W-1:0] ORIGIN_ADDR = 23'h00_0000;

  // ==========================================================================
  // Colour constants
  localparam logic [15:0] TRANSP_DIRECT = 16'h0000;
  localparam logic [31:0] TRANSP_INTERNAL = 32'h0000_0000;
  localparam int DISP_W = 18;             // Internal display colour word
  localparam logic [7:0] CHROMA_BIAS = 8'h80;

  // ==========================================================================
  // Reset values
  localparam logic [DISP_W-1:0] DISP_RESET = 18'h0_0000;
  localparam logic [ADDR_W-2:0] MEM_ADDR_RESET = 22'h00_0000;

  typedef enum logic [1:0] {
    PIX_DIRECT16 = 2'h0,
    PIX_PALETTE8 = 2'h1,
    PIX_YCBCR = 2'h2
  } ugmpa_pix_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT_READ = 2'b10
  } ugmpa_state_t;

  // One pixel access request
  typedef struct packed {
    logic isWrite;                        // 1 write pixel, 0 fetch pixel
    logic linear;                         // Area uses plain byte addresses
    logic pix16;                          // 16 bits per pixel, else 8
    logic memoryWidthSelect;              // 0: 512-pixel rows, 1: 1024
    logic overlay;                        // Foreground or cursor layer
    ugmpa_pix_mode_t pixMode;             // How fetched data is coloured
    logic [X_W-1:0] x;
    logic [Y_W-1:0] y;
    logic [ADDR_W-1:0] linearAddr;        // Used when linear is set
    logic [15:0] writePixel;
  } ugmpa_req_t;

  // Result of colouring one fetched pixel
  typedef struct packed {
    logic transparent;
    logic [DISP_W-1:0] color;
  } ugmpa_color_t;

endpackage

// [ugmpa_color.sv]
// Turns one fetched pixel into the internal display colour word.
// Assumes the palette lookup is done outside and offered on the same cycle.
`timescale 1ns/10ps
module ugmpa_color (
  input wire logic clk,                       // 200 MHz clock
  input wire logic reset_n,                   // Synchronous reset, active low
  input wire logic pixelValid,                // A pixel is offered this cycle
  input wire logic [15:0] pixel,              // Fetched pixel, low byte first
  input wire logic pixelOdd,                  // Pixel sits at an odd X
  input wire ugmpa_pkg::ugmpa_pix_mode_t pixMode, // Pixel format
  input wire logic overlay,                   // Foreground or cursor layer
  input wire logic [31:0] paletteColor,       // Palette entry for 8-bit index
  output ugmpa_pkg::ugmpa_color_t result      // Combinational colour result
);

  logic [7:0] heldCb;
  logic [7:0] heldCr;

  // ==========================================================================
  // Chroma sharing
  // Even pixels carry Cb, odd carry Cr; each pair shares both
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      heldCb <= 8'h00;
      heldCr <= 8'h00;
    end else if (pixelValid && pixMode == ugmpa_pkg::PIX_YCBCR) begin
      if (pixelOdd) begin
        heldCr <= pixel[15:8];
      end else begin
        heldCb <= pixel[15:8];
      end
    end
  end

  function automatic logic [5:0] clamp6(input logic signed [11:0] v);
    if (v < 0) begin
      return 6'h00;
    end else if (v > 255) begin
      return 6'h3f;
    end else begin
      return v[7:2];
    end
  endfunction

  // ==========================================================================
  // Colour conversion
  logic [7:0] lum;
  logic signed [9:0] cb;
  logic signed [9:0] cr;
  logic signed [19:0] rOff;
  logic signed [19:0] gOff;
  logic signed [19:0] bOff;

  always_comb begin
    lum = pixel[7:0];
    // Use the fresh chroma byte for its own half of the pair
    cb = pixelOdd ? $signed({2'b00, heldCb}) : $signed({2'b00, pixel[15:8]});
    cr = pixelOdd ? $signed({2'b00, pixel[15:8]}) : $signed({2'b00, heldCr});
    cb = cb - $signed({2'b00, ugmpa_pkg::CHROMA_BIAS});
    cr = cr - $signed({2'b00, ugmpa_pkg::CHROMA_BIAS});
    rOff = (20'sd359 * 20'(cr)) >>> 8;
    gOff = (20'sd88 * 20'(cb) + 20'sd183 * 20'(cr)) >>> 8;
    bOff = (20'sd454 * 20'(cb)) >>> 8;
    result.transparent = 1'b0;
    result.color = ugmpa_pkg::DISP_RESET;
    unique case (pixMode)
      ugmpa_pkg::PIX_DIRECT16: begin
        // 5:6:5 widened to 6:6:6 by repeating the top bit
        result.color = {pixel[15:11], pixel[15], pixel[10:5], pixel[4:0], pixel[4]};
        result.transparent = overlay && pixel == ugmpa_pkg::TRANSP_DIRECT;
      end
      ugmpa_pkg::PIX_PALETTE8: begin
        result.color = {paletteColor[23:18], paletteColor[15:10], paletteColor[7:2]};
        // A zero entry is see-through wherever it is used
        result.transparent = paletteColor == ugmpa_pkg::TRANSP_INTERNAL;
      end
      ugmpa_pkg::PIX_YCBCR: begin
        result.color = {clamp6(12'(rOff) + 12'(lum)), clamp6(12'(lum) - 12'(gOff)),
                        clamp6(12'(bOff) + 12'(lum))};
        result.transparent = overlay
          && {8'h00, lum, pixel[15:8], 8'h00} == ugmpa_pkg::TRANSP_INTERNAL;
      end
      default: begin
        result.color = ugmpa_pkg::DISP_RESET;
        result.transparent = 1'b0;
      end
    endcase
  end

endmodule

// [ugmpa_core_sva.sv]
// Concurrent checks on the ports of the pixel addressing core.
// Assumes a 32-bit memory bus when byte lanes are checked.
`timescale 1ns/10ps
module ugmpa_core_sva #(
  parameter int MEM_DATA_W = 32
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic reqValid, // Request
  input wire ugmpa_pkg::ugmpa_req_t req, // Request body
  input wire logic busy, // Busy
  input wire logic [ugmpa_pkg::ADDR_W-2:0] memAddress, // A22..A1
  input wire logic memReadStrobe, // Read
  input wire logic memWriteStrobe, // Write
  input wire logic upperByteMask0, // Lane 1
  input wire logic lowerByteMask0, // Lane 0
  input wire logic upperByteMask1, // Lane 3
  input wire logic lowerByteMask1, // Lane 2
  input wire logic memoryDataLinesOe, // Data drive
  input wire logic readDataStrobe, // Data present
  input wire logic displayValid // Colour ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] laneMask;
  logic take;
  ugmpa_pkg::ugmpa_req_t prevReq;
  assign laneMask = {upperByteMask1, lowerByteMask1, upperByteMask0, lowerByteMask0};
  assign take = reqValid && !busy;
  // ==========================================
  // Request one cycle back, for address checks
  always_ff @(posedge clk) begin
    prevReq <= req;
  end
  a_write_launch: assert property (take && req.isWrite |=> memWriteStrobe && memoryDataLinesOe
    ##1 (memWriteStrobe == $past(take && req.isWrite)))
    else $error("write not launched");
  a_read_launch: assert property (take && !req.isWrite |=> memReadStrobe && busy && laneMask == 4'h0)
    else $error("read not launched");
  a_addr_hold: assert property (!take |=> $stable(memAddress))
    else $error("address moved without request");
  a_origin_addr: assert property (take && !req.linear && req.x == 10'h000 && req.y == 14'h0000
    |=> memAddress == 22'h00_0000)
    else $error("origin not at zero");
  a_linear_addr: assert property (take && req.linear |=> memAddress == prevReq.linearAddr[22:1])
    else $error("linear address wrong");
  a_byte_lane: assert property (take && req.isWrite && !req.linear && !req.pix16 && MEM_DATA_W == 32
    |=> laneMask == ~(4'h1 << prevReq.x[1:0]))
    else $error("byte lane mask wrong");
  a_pix16_map: assert property (take && !req.linear && req.pix16 && !req.memoryWidthSelect
    |=> memAddress == {prevReq.y[12:4], prevReq.x[8:4], prevReq.y[3:0], prevReq.x[3:0]})
    else $error("16-bit address map wrong");
  a_color_delay: assert property ($rose(readDataStrobe) && busy |-> ##3 (displayValid && !busy))
    else $error("colour not ready in time");
  c_write: cover property (take && req.isWrite);
  c_linear: cover property (take && req.linear);
  c_color: cover property (displayValid);
endmodule
bind ugmpa_core ugmpa_core_sva #(.MEM_DATA_W(MEM_DATA_W)) chk (.clk, .reset_n, .reqValid, .req,
  .busy, .memAddress, .memReadStrobe, .memWriteStrobe, .upperByteMask0, .lowerByteMask0,
  .upperByteMask1, .lowerByteMask1, .memoryDataLinesOe, .readDataStrobe, .displayValid);

// [ugmpa_mem_model.sv]
// Behavioural graphics memory on a 32-bit data bus.
// Assumes one read at a time; answers after 1 or 6 cycles.
`timescale 1ns/10ps
module ugmpa_mem_model #(
  parameter int MEM_DATA_W = 32
) (
  input wire logic clk, // Clock
  input wire logic [21:0] memAddress, // A22..A1
  input wire logic memReadStrobe, // Read command
  input wire logic memWriteStrobe, // Write command
  input wire logic [3:0] laneMask, // High masks lane
  input wire logic [MEM_DATA_W-1:0] memoryDataLinesOut, // Write data
  input wire logic slow, // Answer late
  output logic [MEM_DATA_W-1:0] memoryDataLinesIn, // Read data
  output logic readDataStrobe // Data present
);
  logic [7:0] mem [int];
  int base;
  // ==========================================
  // Lane l holds byte address 4*word+l
  always @(posedge clk) begin
    if (memWriteStrobe) begin
      for (int l = 0; l < 4; l++) begin
        if (!laneMask[l]) begin
          mem[int'(memAddress[21:1]) * 4 + l] = memoryDataLinesOut[8*l +: 8];
        end
      end
    end
  end
  initial begin
    readDataStrobe = 1'b0;
    memoryDataLinesIn = '0;
    forever begin
      @(posedge clk);
      if (memReadStrobe) begin
        base = int'(memAddress[21:1]) * 4;
        repeat (slow ? 6 : 1) @(posedge clk);
        #1;
        for (int l = 0; l < 4; l++) begin
          memoryDataLinesIn[8*l +: 8] = mem.exists(base + l) ? mem[base + l] : 8'ha5;
        end
        readDataStrobe = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        readDataStrobe = 1'b0;
        // Released bus must not keep showing old data
        memoryDataLinesIn = ~memoryDataLinesIn;
      end
    end
  end
endmodule

// [test_graphics_memory_pixel_addressing.sv]
// Self-checking bench: writes pixels, reads them back, checks colours.
// Assumes a 32-bit memory bus and the behavioural memory model.
`timescale 1ns/10ps
module test_graphics_memory_pixel_addressing;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reqValid = 1'b0;
  logic slowMem = 1'b0;
  ugmpa_pkg::ugmpa_req_t req = '0;
  logic [31:0] paletteColor = '0;
  logic [31:0] memIn, memOut;
  logic readDataStrobe, busy, memReadStrobe, memWriteStrobe, memOe, displayValid, transp;
  logic upperByteMask0, lowerByteMask0, upperByteMask1, lowerByteMask1;
  logic [21:0] memAddress;
  logic [17:0] colorWord;
  wire logic [3:0] laneMask = {upperByteMask1, lowerByteMask1, upperByteMask0, lowerByteMask0};
  int failCount = 0;
  int nTests = 0;
  int seed = 51187;
  logic [7:0] shadow [int];
  always #2.5 clk = ~clk;
  ugmpa_core #(.MEM_DATA_W(32)) DUT (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
    .req(req), .paletteColor(paletteColor), .memoryDataLinesIn(memIn),
    .readDataStrobe(readDataStrobe), .busy(busy), .memAddress(memAddress),
    .memReadStrobe(memReadStrobe), .memWriteStrobe(memWriteStrobe),
    .upperByteMask0(upperByteMask0), .lowerByteMask0(lowerByteMask0),
    .upperByteMask1(upperByteMask1), .lowerByteMask1(lowerByteMask1),
    .memoryDataLinesOut(memOut), .memoryDataLinesOe(memOe), .displayValid(displayValid),
    .internalDisplayColorWord(colorWord), .pixelTransparent(transp));
  ugmpa_mem_model #(.MEM_DATA_W(32)) partner (.clk(clk), .memAddress(memAddress),
    .memReadStrobe(memReadStrobe), .memWriteStrobe(memWriteStrobe), .laneMask(laneMask),
    .memoryDataLinesOut(memOut), .slow(slowMem), .memoryDataLinesIn(memIn),
    .readDataStrobe(readDataStrobe));
  // ==========================================
  // Compare and verdict
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task giveVerdict;
    if (failCount == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Host-side view of the coordinate to byte address map
  function automatic int byteAddr(ugmpa_pkg::ugmpa_req_t r);
    int xl, xu;
    xl = r.pix16 ? 4 : 5;
    xu = (r.memoryWidthSelect ? 6 : 5) - (r.pix16 ? 0 : 1);
    if (r.linear) return int'(r.linearAddr);
    return (((((int'(r.y) >> 4) << xu | (int'(r.x) >> xl) & ((1 << xu) - 1)) << 4
      | int'(r.y) & 15) << xl | int'(r.x) & ((1 << xl) - 1)) << r.pix16) & 32'h007f_ffff;
  endfunction
  // ==========================================
  // Bus tasks, entered at a falling edge
  task automatic doWrite(ugmpa_pkg::ugmpa_req_t r);
    int a;
    int lane;
    logic [3:0] em;
    r.isWrite = 1'b1;
    reqValid <= 1'b1;
    req <= r;
    @(negedge clk);
    a = byteAddr(r);
    lane = a & 3;
    shadow[a] = r.writePixel[7:0];
    if (r.pix16) shadow[a + 1] = r.writePixel[15:8];
    em = r.pix16 ? ~(4'h3 << lane) : ~(4'h1 << lane);
    check(memWriteStrobe & memOe, 1);
    check(memAddress, a >> 1);
    check(laneMask, em);
    check(r.pix16 ? memOut[8*lane +: 16] : memOut[8*lane +: 8],
      r.pix16 ? r.writePixel : r.writePixel[7:0]);
  endtask
  task automatic doRead(ugmpa_pkg::ugmpa_req_t r, logic [17:0] ec, logic et, logic cc);
    int i;
    r.isWrite = 1'b0;
    reqValid <= 1'b1;
    req <= r;
    @(negedge clk);
    check(memReadStrobe, 1);
    check(laneMask, 4'h0);
    @(negedge clk);
    reqValid <= 1'b0;
    check(memReadStrobe, 0);
    for (i = 0; i < 40 && displayValid !== 1'b1; i++) @(negedge clk);
    check(displayValid, 1);
    if (cc) check(colorWord, ec);
    check(transp, et);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    ugmpa_pkg::ugmpa_req_t r;
    ugmpa_pkg::ugmpa_req_t q[$];
    logic [15:0] p;
    logic [31:0] pc;
    int i;
    repeat (20) @(negedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check(laneMask, 4'hf);
    check({memAddress, busy, memReadStrobe, memWriteStrobe, displayValid}, 0);
    for (i = 0; i < 60; i++) begin
      r = '0;
      r.pix16 = $random(seed);
      r.memoryWidthSelect = $random(seed);
      r.x = $random(seed);
      if (!r.memoryWidthSelect) r.x[9] = 1'b0;
      r.y = $random(seed) & 14'h07ff;
      // One write lands on the coordinate origin
      if (i == 3) {r.x, r.y} = '0;
      r.writePixel = $random(seed);
      r.linear = (i % 8 == 7);
      r.linearAddr = $random(seed);
      if (r.pix16) r.linearAddr[0] = 1'b0;
      q.push_back(r);
      doWrite(r);
    end
    reqValid <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 60; i++) begin
      r = q[i];
      p = r.pix16 ? {shadow[byteAddr(r) + 1], shadow[byteAddr(r)]} : shadow[byteAddr(r)];
      pc = (i % 4 == 0) ? 32'h0000_0000 : $random(seed);
      paletteColor <= pc;
      slowMem <= $random(seed);
      r.overlay = 1'b1;
      r.pixMode = r.pix16 ? ugmpa_pkg::PIX_DIRECT16 : ugmpa_pkg::PIX_PALETTE8;
      if (r.pix16) doRead(r, {p[15:11], p[15], p[10:5], p[4:0], p[4]}, p == 0, 1);
      else doRead(r, {pc[23:18], pc[15:10], pc[7:2]}, pc == 0, 1);
    end
    for (i = 0; i < 4; i++) begin
      r = '0;
      r.pix16 = 1'b1;
      r.x = 10'(32 + 2 * i);
      r.y = 14'h0005;
      r.writePixel = (i == 3) ? 16'h0010 : 16'h0000;
      r.overlay = (i != 1);
      r.pixMode = (i < 2) ? ugmpa_pkg::PIX_DIRECT16 : ugmpa_pkg::PIX_YCBCR;
      doWrite(r);
      reqValid <= 1'b0;
      @(negedge clk);
      doRead(r, 18'h0_0000, i == 0 || i == 2, i < 2);
    end
    giveVerdict;
  end
  // Cuts a hang short well past the expected run
  initial begin
    #50000;
    failCount++;
    giveVerdict;
  end
endmodule
